// [src/scpg_pkg.sv]
// constants and types shared by the switching clock and power-good block
package scpg_pkg;
	// ==========================================================
	// register map, one aligned word each
	localparam logic [11:0] REG_CTRL  = 12'h000;
	localparam logic [11:0] REG_PGWIN = 12'h004;
	localparam logic [11:0] REG_PGDLY = 12'h008;
	localparam logic [11:0] REG_FREQ  = 12'h00c;
	localparam logic [11:0] REG_STAT  = 12'h010;
	// control fields and reset values
	localparam int          CTRL_POL   = 0;
	localparam int          CTRL_FOVR  = 1;
	localparam int          CTRL_DOVR  = 2;
	localparam logic [2:0]  CTRL_RST   = 3'h1;
	localparam logic [7:0]  PG_LO_RST  = 8'h5a;
	localparam logic [7:0]  PG_HI_RST  = 8'h73;
	localparam logic [7:0]  PG_DLY_RST = 8'h0a;
	localparam logic [10:0] FREQ_RST   = 11'h190;
	localparam logic [23:0] PCT_FULL   = 24'h000064;
	// ==========================================================
	// strap codes
	localparam logic [1:0] STRAP_LOW  = 2'h0;
	localparam logic [1:0] STRAP_OPEN = 2'h1;
	localparam logic [1:0] STRAP_HIGH = 2'h2;
	localparam logic [1:0] STRAP_RES  = 2'h3;
	// ==========================================================
	// frequency synthesis
	localparam int         BASE_KHZ  = 8000;
	localparam logic [7:0] CLK_MHZ   = 8'h64;
	localparam logic [7:0] BASE_MHZ  = 8'h08;
	localparam logic [5:0] N_MIN     = 6'h06;
	localparam logic [5:0] N_MAX     = 6'h28;
	localparam logic [5:0] OUT_N     = 6'h14;
	localparam logic [6:0] LOSS_TICK = 7'h30;
	localparam logic [10:0] KHZ_LOW  = 11'h0c8;
	localparam logic [10:0] KHZ_OPEN = 11'h190;
	localparam logic [10:0] KHZ_HIGH = 11'h3e8;
	// ==========================================================
	// timing
	localparam int CLK_NS    = 10;
	localparam int MS_NS     = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	localparam logic [7:0] RAMP_2  = 8'h02;
	localparam logic [7:0] RAMP_5  = 8'h05;
	localparam logic [7:0] RAMP_10 = 8'h0a;
	localparam logic [7:0] RAMP_20 = 8'h14;
	// ==========================================================
	// clock source states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_DET  = 4'b0010,
		ST_SYNC = 4'b0100,
		ST_FREE = 4'b1000
	} scpg_state_t;
endpackage

// [src/scpg_top.sv]
// switching clock source selection and power-good qualification
// Summary of operation
// - power-good asserted only inside -10%/+15% window with no fault
// - host may reprogram window limits and power-good polarity
// - power-good waits a delay, default equal to soft-start ramp time
// - host may program power-good delay independently of ramp
// - mode strap low input, open auto-detect, high output
// - output mode runs internal 400 kHz and drives pin, never samples
// - input mode checks clock at each enable and locks to rising edges
// - on clock loss fall back to internal near previous frequency
// - auto-detect checks clock after enable and syncs like input mode
// - auto-detect without clock uses sync strap: 200k, 400k, 1M, resistor
// - sync strap sampled only at start-up
// - resistor index maps through table 200 kHz to 1333 kHz
// - host may write any frequency 200 kHz to 1.33 MHz
// - frequency is 8 MHz over integer divisor 6 to 40
// - non-exact request picks a whole divisor giving a close value
// - read-back frequency is the quantised hardware value
// - soft-start strap picks ramp of 2, 5, 10 or 20 ms
`timescale 1ns/1ps
module scpg_top #(
	parameter int MS_CYC = scpg_pkg::MS_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] vout_mv,
	input  wire logic [15:0] vtarget_mv,
	input  wire logic        fault,
	input  wire logic        en_pin,
	input  wire logic        sync_i,
	input  wire logic [1:0]  mode_strap,
	input  wire logic [1:0]  sync_strap,
	input  wire logic [4:0]  res_sel,
	input  wire logic [1:0]  ss_sel,
	output logic             sync_o,
	output logic             sync_oe,
	output logic             sw_tick,
	output logic      [5:0]  sw_div,
	output logic             output_in_regulation_flag
);
	import scpg_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic [5:0] nearest_n(input logic [10:0] khz);
		int best;
		int err;
		int berr;
		best = int'(N_MIN);
		berr = 32'h7fffffff;
		for (int i = int'(N_MIN); i <= int'(N_MAX); i++) begin
			err = BASE_KHZ - int'(khz) * i;
			if (err < 0) begin
				err = -err;
			end
			if (err < berr) begin
				berr = err;
				best = i;
			end
		end
		return 6'(best); // rounds and clamps in one search
	endfunction

	function automatic logic [10:0] n_khz(input logic [5:0] n);
		return 11'(BASE_KHZ / int'(n)); // quantised value
	endfunction

	function automatic logic [5:0] clamp_n(input logic [6:0] c);
		if (c < 7'(N_MIN)) begin
			return N_MIN;
		end else if (c > 7'(N_MAX)) begin
			return N_MAX;
		end
		return c[5:0]; // divisor kept inside 6..40
	endfunction

	// resistor index to nominal kHz
	function automatic logic [10:0] res_khz(input logic [4:0] idx);
		case (idx)
			5'h00: return 11'h0c8;
			5'h01: return 11'h0de;
			5'h02: return 11'h0f2;
			5'h03: return 11'h10b;
			5'h04: return 11'h128;
			5'h05: return 11'h140;
			5'h06: return 11'h16c;
			5'h07: return 11'h190;
			5'h08: return 11'h1a5;
			5'h09: return 11'h1d7;
			5'h0a: return 11'h215;
			5'h0b: return 11'h23b;
			5'h0c: return 11'h267;
			5'h0d: return 11'h2d7;
			5'h0e: return 11'h320;
			5'h0f: return 11'h379;
			5'h10: return 11'h3e8;
			5'h11: return 11'h477;
			5'h12: return 11'h535;
			default: return 11'h190;
		endcase
	endfunction

	function automatic logic [7:0] ramp_ms(input logic [1:0] sel);
		case (sel)
			2'h0: return RAMP_2;
			2'h1: return RAMP_5;
			2'h2: return RAMP_10;
			default: return RAMP_20;
		endcase
	endfunction

	// ==========================================================
	// pin synchronisers and start-up strap capture
	logic [12:0] pin_m;
	logic [12:0] pin_s;
	logic [1:0]  boot;
	logic [1:0]  mode_q;
	logic [1:0]  strap_q;
	logic [4:0]  res_q;
	logic [1:0]  ss_q;

	// straps are static, but still pass two flops like any pin
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_m <= 13'h0000;
			pin_s <= 13'h0000;
		end else begin
			pin_m <= {en_pin, sync_i, mode_strap, sync_strap, res_sel, ss_sel};
			pin_s <= pin_m;
		end
	end

	logic [1:0] next_boot;
	logic [1:0] next_mode_q;
	logic [1:0] next_strap_q;
	logic [4:0] next_res_q;
	logic [1:0] next_ss_q;
	// straps latched once, later changes need a power cycle
	always_comb begin
		next_boot    = boot;
		next_mode_q  = mode_q;
		next_strap_q = strap_q;
		next_res_q   = res_q;
		next_ss_q    = ss_q;
		if (boot != 2'h3) begin
			next_boot = boot + 2'h1;
		end
		if (boot == 2'h2) begin
			next_mode_q  = pin_s[10:9];
			next_strap_q = pin_s[8:7];
			next_res_q   = pin_s[6:2];
			next_ss_q    = pin_s[1:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			boot    <= 2'h0;
			mode_q  <= STRAP_OPEN;
			strap_q <= STRAP_OPEN;
			res_q   <= 5'h00;
			ss_q    <= 2'h0;
		end else begin
			boot    <= next_boot;
			mode_q  <= next_mode_q;
			strap_q <= next_strap_q;
			res_q   <= next_res_q;
			ss_q    <= next_ss_q;
		end
	end

	logic en_s;
	logic sync_s;
	logic booted;
	assign en_s   = pin_s[12];
	assign sync_s = pin_s[11];
	assign booted = (boot == 2'h3);

	// ==========================================================
	// apb slave and registers
	logic [2:0]  ctrl;
	logic [7:0]  pg_lo;
	logic [7:0]  pg_hi;
	logic [7:0]  pg_dly;
	logic [5:0]  host_n;
	scpg_state_t st;
	logic [5:0]  act_n;
	logic        pg_ok;

	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic [2:0]  next_ctrl;
	logic [7:0]  next_pg_lo;
	logic [7:0]  next_pg_hi;
	logic [7:0]  next_pg_dly;
	logic [5:0]  next_host_n;
	logic        wr;
	// one wait-free access: answer prepared in setup, taken in access
	always_comb begin
		next_ctrl     = ctrl;
		next_pg_lo    = pg_lo;
		next_pg_hi    = pg_hi;
		next_pg_dly   = pg_dly;
		next_host_n   = host_n;
		next_pready   = psel && !penable;
		next_prdata   = prdata;
		next_pslverr  = 1'b0;
		if (psel && !penable) begin
			case (paddr)
				REG_CTRL:  next_prdata = {29'h0, ctrl};
				REG_PGWIN: next_prdata = {16'h0, pg_hi, pg_lo};
				REG_PGDLY: next_prdata = {24'h0, pg_dly};
				REG_FREQ:  next_prdata = {21'h0, n_khz(host_n)};
				REG_STAT:  next_prdata = {2'h0, pg_ok,
					output_in_regulation_flag, st, 2'h0, act_n, 5'h00,
					n_khz(act_n)};
				default:   next_prdata = 32'h00000000;
			endcase
			next_pslverr = (paddr > REG_STAT) || (paddr[1:0] != 2'h0)
				|| (pwrite && paddr == REG_STAT);
		end
		wr = psel && penable && pready && pwrite && !pslverr;
		if (wr) begin
			case (paddr)
				REG_CTRL: next_ctrl = pwdata[2:0];
				REG_PGWIN: begin
					next_pg_lo = pwdata[7:0];
					next_pg_hi = pwdata[15:8];
				end
				REG_PGDLY: next_pg_dly = pwdata[7:0];
				REG_FREQ: next_host_n = nearest_n(pwdata[10:0]);
				default: next_ctrl = ctrl;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata   <= 32'h00000000;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			ctrl     <= CTRL_RST;
			pg_lo    <= PG_LO_RST;
			pg_hi    <= PG_HI_RST;
			pg_dly   <= PG_DLY_RST;
			host_n   <= OUT_N;
		end else begin
			prdata   <= next_prdata;
			pready   <= next_pready;
			pslverr  <= next_pslverr;
			ctrl     <= next_ctrl;
			pg_lo    <= next_pg_lo;
			pg_hi    <= next_pg_hi;
			pg_dly   <= next_pg_dly;
			host_n   <= next_host_n;
		end
	end

	// ==========================================================
	// clock source selection and switching clock
	logic [6:0] acc;
	logic [6:0] cnt;
	logic [5:0] ph;
	logic       seen;
	logic       held;
	logic       en_d;
	logic       sync_d;
	logic [5:0] strap_n;
	logic [5:0] cfg_n;

	// fallback divisor when no clock is found
	always_comb begin
		case (strap_q)
			STRAP_LOW:  strap_n = nearest_n(KHZ_LOW);
			STRAP_OPEN: strap_n = nearest_n(KHZ_OPEN);
			STRAP_HIGH: strap_n = nearest_n(KHZ_HIGH);
			default:    strap_n = nearest_n(res_khz(res_q));
		endcase
		if (ctrl[CTRL_FOVR]) begin
			cfg_n = host_n;
		end else if (mode_q == STRAP_OPEN) begin
			cfg_n = strap_n;
		end else begin
			cfg_n = OUT_N;
		end
	end

	scpg_state_t next_st;
	logic [6:0]  next_acc;
	logic [6:0]  next_cnt;
	logic [5:0]  next_ph;
	logic [5:0]  next_act_n;
	logic        next_seen;
	logic        next_held;
	logic        next_tick;
	logic        next_sync_o;
	logic        next_sync_oe;
	logic [7:0]  sum;
	logic        base;
	logic        edge_s;
	// 8 MHz base as a fractional enable: 8 of every 100 cycles
	always_comb begin
		sum        = {1'b0, acc} + BASE_MHZ;
		base       = (sum >= CLK_MHZ);
		next_acc   = base ? 7'(sum - CLK_MHZ) : sum[6:0];
		edge_s     = sync_s && !sync_d && (mode_q != STRAP_HIGH);
		next_st    = st;
		next_cnt   = cnt;
		next_ph    = ph;
		next_act_n = act_n;
		next_seen  = seen;
		next_held  = held;
		next_tick  = 1'b0;
		case (st)
			ST_IDLE: begin
				if (booted && en_s && !en_d) begin
					next_held = 1'b0;
					next_ph   = 6'h00;
					if (mode_q == STRAP_HIGH) begin
						next_st    = ST_FREE;
						next_act_n = OUT_N;
					end else begin
						next_st   = ST_DET;
						next_cnt  = 7'h00;
						next_seen = 1'b0;
					end
				end
			end
			ST_DET: begin
				if (edge_s) begin
					next_cnt  = 7'h00;
					next_seen = 1'b1;
					if (seen) begin
						next_st    = ST_SYNC;
						next_act_n = clamp_n(cnt);
						next_ph    = 6'h00;
						next_tick  = 1'b1;
					end
				end else if (base) begin
					next_cnt = cnt + 7'h01;
					if (cnt >= LOSS_TICK) begin
						next_st    = ST_FREE;
						next_act_n = cfg_n;
					end
				end
			end
			ST_SYNC: begin
				if (edge_s) begin
					next_act_n = clamp_n(cnt); // lock to rising edge
					next_cnt   = 7'h00;
					next_ph    = 6'h00;
					next_tick  = 1'b1;
				end else if (base) begin
					next_cnt = cnt + 7'h01;
					if (cnt >= LOSS_TICK) begin
						next_st   = ST_FREE; // keep last period
						next_held = 1'b1;
					end
				end
			end
			ST_FREE: begin
				if (!held && mode_q != STRAP_HIGH) begin
					next_act_n = cfg_n; // host changes apply live
				end
				if (base) begin
					if (ph >= act_n - 6'h01) begin
						next_ph   = 6'h00; // divide base by n
						next_tick = 1'b1;
					end else begin
						next_ph = ph + 6'h01;
					end
				end
			end
			default: next_st = ST_IDLE;
		endcase
		if (!en_s) begin
			next_st   = ST_IDLE;
			next_tick = 1'b0;
		end
		next_sync_oe = booted && (mode_q == STRAP_HIGH);
		next_sync_o  = next_sync_oe && (st == ST_FREE)
			&& (ph < (act_n >> 1));
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st      <= ST_IDLE;
			acc     <= 7'h00;
			cnt     <= 7'h00;
			ph      <= 6'h00;
			act_n   <= OUT_N;
			seen    <= 1'b0;
			held    <= 1'b0;
			en_d    <= 1'b0;
			sync_d  <= 1'b0;
			sw_tick <= 1'b0;
			sw_div  <= OUT_N;
			sync_o  <= 1'b0;
			sync_oe <= 1'b0;
		end else begin
			st      <= next_st;
			acc     <= next_acc;
			cnt     <= next_cnt;
			ph      <= next_ph;
			act_n   <= next_act_n;
			seen    <= next_seen;
			held    <= next_held;
			en_d    <= en_s;
			sync_d  <= sync_s;
			sw_tick <= next_tick;
			sw_div  <= next_act_n;
			sync_o  <= next_sync_o;
			sync_oe <= next_sync_oe;
		end
	end

	// ==========================================================
	// power-good qualification and delay
	logic [16:0] ms_div;
	logic [7:0]  ms_cnt;
	logic [16:0] next_ms_div;
	logic [7:0]  next_ms_cnt;
	logic        next_pg_ok;
	logic        next_pg_pin;
	logic        qual;
	logic [7:0]  dly;
	// window in percent of target; products fit 24 bits
	always_comb begin
		qual = en_s && !fault && (st != ST_IDLE)
			&& (24'(vout_mv) * PCT_FULL >= 24'(vtarget_mv) * 24'(pg_lo))
			&& (24'(vout_mv) * PCT_FULL <= 24'(vtarget_mv) * 24'(pg_hi));
		dly = ctrl[CTRL_DOVR] ? pg_dly : ramp_ms(ss_q);
		next_ms_div = ms_div;
		next_ms_cnt = ms_cnt;
		next_pg_ok  = 1'b0;
		if (!qual) begin
			next_ms_div = 17'h00000; // drop at once, restart delay
			next_ms_cnt = 8'h00;
		end else if (ms_cnt >= dly) begin
			next_pg_ok = 1'b1;
		end else if (ms_div >= 17'(MS_CYC - 1)) begin
			next_ms_div = 17'h00000;
			next_ms_cnt = ms_cnt + 8'h01;
		end else begin
			next_ms_div = ms_div + 17'h00001;
		end
		next_pg_pin = !(next_pg_ok ^ ctrl[CTRL_POL]);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ms_div <= 17'h00000;
			ms_cnt <= 8'h00;
			pg_ok  <= 1'b0;
			output_in_regulation_flag <= 1'b0;
		end else begin
			ms_div <= next_ms_div;
			ms_cnt <= next_ms_cnt;
			pg_ok  <= next_pg_ok;
			output_in_regulation_flag <= next_pg_pin;
		end
	end
endmodule // scpg_top

// [tb/scpg_properties.sv]
// assertion checker for the switching clock and power-good block
`timescale 1ns/1ps
module scpg_checker (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       fault,
	input wire logic       en_pin,
	input wire logic [1:0] mode_strap,
	input wire logic       sync_oe,
	input wire logic       sw_tick,
	input wire logic [5:0] sw_div,
	input wire logic       output_in_regulation_flag
);
	import scpg_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// ==========================================================
	// cycles since the last switching tick while enabled
	logic [10:0] gap_cnt;
	logic [10:0] next_gap_cnt;
	always_comb begin
		next_gap_cnt = gap_cnt + 11'h001;
		if (sw_tick || !en_pin)
			next_gap_cnt = 11'h000;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			gap_cnt <= 11'h000;
		else
			gap_cnt <= next_gap_cnt;
	end
	// ==========================================================
	// bus steps
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	property p_apb_answer;
		s_setup |=> s_access;
	endproperty
	property p_apb_once;
		s_access |=> !pready;
	endproperty
	// ==========================================================
	// clock source
	property p_oe_mode;
		sync_oe |-> mode_strap == STRAP_HIGH;
	endproperty
	property p_out_div;
		sync_oe |-> sw_div == OUT_N;
	endproperty
	property p_div_range;
		sw_div >= N_MIN && sw_div <= N_MAX;
	endproperty
	// shortest legal period is far above eight cycles
	property p_tick_gap;
		sw_tick |=> !sw_tick [*8];
	endproperty
	// detect timeout plus slowest free period stays below this
	property p_tick_alive;
		gap_cnt < 11'h514;
	endproperty
	property p_pg_fault;
		fault [*6] |-> $stable(output_in_regulation_flag);
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("no answer after setup");
	a_apb_once: assert property (p_apb_once)
		else $error("ready held past one cycle");
	a_oe_mode: assert property (p_oe_mode)
		else $error("pin driven outside output mode");
	a_out_div: assert property (p_out_div)
		else $error("output mode divisor wrong");
	a_div_range: assert property (p_div_range)
		else $error("divisor out of range");
	a_tick_gap: assert property (p_tick_gap)
		else $error("ticks too close");
	a_tick_alive: assert property (p_tick_alive)
		else $error("switching ticks stopped");
	a_pg_fault: assert property (p_pg_fault)
		else $error("power-good moved during fault");
endmodule // scpg_checker

bind scpg_top scpg_checker u_chk (
	.clk(clk),
	.arst_n(arst_n),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.fault(fault),
	.en_pin(en_pin),
	.mode_strap(mode_strap),
	.sync_oe(sync_oe),
	.sw_tick(sw_tick),
	.sw_div(sw_div),
	.output_in_regulation_flag(output_in_regulation_flag)
);

// [tb/scpg_sync_src.sv]
// external clock source sharing the synchronisation line
`timescale 1ns/1ps
module scpg_sync_src #(
	parameter int HALF_NS = 1000
) (
	input  wire logic run,
	output logic      line
);
	// ==========================================================
	// 500 kHz, started before enable; line rests low when stopped
	initial begin
		line = 1'b0;
		#3;
		forever begin
			wait (run);
			#HALF_NS line = 1'b1;
			#HALF_NS line = 1'b0;
		end
	end
endmodule // scpg_sync_src

// [tb/scpg_bench.sv]
// self-checking bench for the switching clock and power-good block
`timescale 1ns/1ps
module scpg_bench;
	import scpg_pkg::*;
	logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] vout_mv, vtarget_mv;
	logic        fault, en_pin, sync_i, sync_o, sync_oe, sw_tick;
	logic        pg, run, ext, err;
	logic [1:0]  mode_strap, sync_strap, ss_sel;
	logic [4:0]  res_sel;
	logic [5:0]  sw_div, held_div;
	int          bad_count, checks_done;
	// shared pin: the device wins only while it drives
	assign sync_i = sync_oe ? sync_o : ext;
	scpg_sync_src u_src (.run(run), .line(ext));
	scpg_top #(.MS_CYC(10)) dut (
		.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.vout_mv(vout_mv), .vtarget_mv(vtarget_mv), .fault(fault),
		.en_pin(en_pin), .sync_i(sync_i), .mode_strap(mode_strap),
		.sync_strap(sync_strap), .res_sel(res_sel), .ss_sel(ss_sel),
		.sync_o(sync_o), .sync_oe(sync_oe), .sw_tick(sw_tick),
		.sw_div(sw_div), .output_in_regulation_flag(pg)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========================================================
	// helpers
	task close_out;
		$display("checks=%0d mismatches=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one transfer, held until ready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk({31'h0, pready}, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			close_out();
		@(posedge clk);
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// polling the status word, bounded
	task wait_st(input logic [3:0] st);
		int n;
		n = 0;
		do begin
			apb(1'b0, REG_STAT, 32'h0);
			n++;
		end while (rd[27:24] !== st && n < 400);
		chk({28'h0, rd[27:24]}, {28'h0, st});
		if (rd[27:24] !== st)
			close_out();
	endtask
	// mid-run reset with new straps, held like a power cycle
	task reboot(input logic [1:0] m, input logic [1:0] s,
		input logic [4:0] r, input logic [1:0] f);
		en_pin <= 1'b0;
		arst_n <= 1'b0;
		mode_strap <= m;
		sync_strap <= s;
		res_sel <= r;
		ss_sel <= f;
		cyc(16);
		arst_n <= 1'b1;
		cyc(5);
	endtask
	// ==========================================================
	// scenarios
	task t_regs;
		rchk(REG_CTRL, 32'h1);
		rchk(REG_PGWIN, 32'h735a);
		rchk(REG_PGDLY, 32'ha);
		apb(1'b0, 12'h014, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, REG_STAT, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask
	task t_host;
		logic [10:0] req [4];
		logic [10:0] exp [4];
		req = '{11'h32a, 11'h535, 11'h064, 11'h7d0};
		exp = '{11'h320, 11'h535, 11'h0c8, 11'h535};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, REG_FREQ, {21'h0, req[i]});
			rchk(REG_FREQ, {21'h0, exp[i]});
		end
	endtask
	task t_auto;
		en_pin <= 1'b1;
		wait_st(4'h8);
		chk({26'h0, sw_div}, 32'h8);
		chk({21'h0, rd[10:0]}, 32'h3e8);
		sync_strap <= STRAP_LOW;
		en_pin <= 1'b0;
		cyc(10);
		en_pin <= 1'b1;
		wait_st(4'h8);
		chk({26'h0, sw_div}, 32'h8);
		apb(1'b1, REG_FREQ, 32'h32a);
		apb(1'b1, REG_CTRL, 32'h3);
		cyc(600);
		chk({26'h0, sw_div}, 32'ha);
		apb(1'b1, REG_CTRL, 32'h1);
	endtask
	task t_sync;
		en_pin <= 1'b0;
		run <= 1'b1;
		cyc(400);
		en_pin <= 1'b1;
		wait_st(4'h4);
		cyc(400);
		held_div = sw_div;
		chk({31'h0, held_div >= 6'h0f && held_div <= 6'h11}, 32'h1);
		run <= 1'b0;
		wait_st(4'h8);
		chk({26'h0, sw_div}, {26'h0, held_div});
	endtask
	task t_pg;
		logic [15:0] v [4];
		logic        e [4];
		v = '{16'h047f, 16'h047e, 16'h0383, 16'h0384};
		e = '{1'b0, 1'b1, 1'b0, 1'b1};
		vout_mv <= 16'h03e8;
		cyc(15);
		chk({31'h0, pg}, 32'h0);
		cyc(12);
		chk({31'h0, pg}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			vout_mv <= v[i];
			cyc(30);
			chk({31'h0, pg}, {31'h0, e[i]});
		end
		apb(1'b1, REG_PGDLY, 32'h5);
		apb(1'b1, REG_CTRL, 32'h5);
		vout_mv <= 16'h0000;
		cyc(5);
		vout_mv <= 16'h03e8;
		cyc(40);
		chk({31'h0, pg}, 32'h0);
		cyc(16);
		chk({31'h0, pg}, 32'h1);
		apb(1'b1, REG_CTRL, 32'h4);
		cyc(3);
		chk({31'h0, pg}, 32'h0);
		fault <= 1'b1;
		cyc(4);
		chk({31'h0, pg}, 32'h1);
		cyc(4);
		fault <= 1'b0;
	endtask
	task t_out;
		int  n;
		int  m;
		logic prv;
		reboot(STRAP_HIGH, STRAP_HIGH, 5'h00, 2'h0);
		en_pin <= 1'b1;
		wait_st(4'h8);
		chk({31'h0, sync_oe}, 32'h1);
		chk({26'h0, sw_div}, 32'h14);
		n = 0;
		m = 0;
		prv = sync_o;
		repeat (1000) begin
			@(posedge clk);
			if (sync_o && !prv)
				n++;
			if (sw_tick)
				m++;
			prv = sync_o;
		end
		chk(n, 32'h4);
		chk(m, 32'h4);
	endtask
	// resistor strap in auto mode, 46.4k entry, 20 ms ramp
	task t_res;
		vout_mv <= 16'h0000;
		reboot(STRAP_OPEN, STRAP_RES, 5'h0f, 2'h3);
		en_pin <= 1'b1;
		wait_st(4'h8);
		chk({26'h0, sw_div}, 32'h9);
		chk({21'h0, rd[10:0]}, 32'h378);
		vout_mv <= 16'h03e8;
		cyc(190);
		chk({31'h0, pg}, 32'h0);
		cyc(20);
		chk({31'h0, pg}, 32'h1);
	endtask
	// input mode: clock running before enable, pin never driven
	task t_input;
		run <= 1'b1;
		reboot(STRAP_LOW, STRAP_HIGH, 5'h00, 2'h0);
		cyc(400);
		en_pin <= 1'b1;
		wait_st(4'h4);
		chk({31'h0, sync_oe}, 32'h0);
		cyc(400);
		chk({31'h0, sw_div >= 6'h0f && sw_div <= 6'h11}, 32'h1);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		bad_count = 0;
		checks_done = 0;
		arst_n = 1'b0;
		{psel, penable, pwrite, fault, en_pin, run} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		vout_mv = 16'h0000;
		vtarget_mv = 16'h03e8;
		mode_strap = STRAP_OPEN;
		sync_strap = STRAP_HIGH;
		res_sel = 5'h00;
		ss_sel = 2'h0;
		cyc(16);
		arst_n <= 1'b1;
		cyc(5);
		t_regs();
		t_host();
		t_auto();
		t_sync();
		t_pg();
		t_out();
		t_res();
		t_input();
		close_out();
	end
endmodule // scpg_bench
